// *** mic_interrupt_unit.sv ***
/*
 * Interrupt unit: request flags, priorities, fast source, transfer-controller hand-off,
 * non-maskable sources and wake-up from low power modes.
 * Assumes all inputs synchronous to sys_clk, a word-indexed register port, and
 * one-cycle acknowledge pulses from the CPU and the transfer controller.
 */
`timescale 1ns/1ps
`include "mic_regs.svh"

module mic_interrupt_unit #(
    parameter int PRIO_W = 4,
    parameter logic [255:0] LEVEL_MASK = '0,
    parameter logic [7:0] SW_VEC = 8'h1b,
    parameter logic [7:0] PIN_BASE_VEC = 8'h40,
    parameter logic [7:0] EVA_VEC = 8'h6a,
    parameter logic [7:0] EVB_VEC = 8'h6b,
    parameter logic [7:0] RTC_ALM_VEC = 8'h5c,
    parameter logic [7:0] RTC_PRD_VEC = 8'h5d
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [9:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [255:0] periphReq,
    input wire logic [7:0] extPin,
    input wire logic nmiPin,
    input wire logic eventLinkA,
    input wire logic eventLinkB,
    input wire logic rtcAlarm,
    input wire logic rtcPeriod,
    input wire logic oscStop,
    input wire logic watchdogFault,
    input wire logic voltMonOne,
    input wire logic voltMonTwo,
    input wire logic cpuAck,
    input wire logic dtcAck,
    output logic cpuIrq,
    output logic [7:0] cpuVec,
    output logic [PRIO_W-1:0] cpuLevel,
    output logic cpuFast,
    output logic dtcReq,
    output logic [7:0] dtcVec,
    output logic nmiIrq,
    output logic wakeReq
);

    // ****************************************
    // pin filters
    // ****************************************
    logic [8:0] filtEn;
    logic [8:0] pinRaw;
    logic [8:0] pinF;
    assign pinRaw = {nmiPin, extPin};

    genvar g;
    generate
        for (g = 0; g < 9; g++) begin : gFilt
            mic_pin_filter #(.LEN(`MIC_FILT_LEN), .IDLE(1'b1)) uFilt (
                .sys_clk(sys_clk),
                .rst(rst),
                .enable(filtEn[g]),
                .pin(pinRaw[g]),
                .filtered(pinF[g])
            );
        end
    endgenerate

    // ****************************************
    // register state
    // ****************************************
    logic [PRIO_W-1:0] prio [256];
    logic [PRIO_W-1:0] next_prio [256];
    logic [255:0] dtcEn;
    logic [255:0] next_dtcEn;
    logic [8:0] fastSel;
    logic [8:0] next_fastSel;
    logic [15:0] pinMode;
    logic [15:0] next_pinMode;
    logic [8:0] next_filtEn;
    logic nmiEdgeRise;
    logic next_nmiEdgeRise;
    logic [4:0] nmiEn;
    logic [4:0] next_nmiEn;
    mic_pkg::mic_power_e power;
    mic_pkg::mic_power_e next_power;
    logic swPulse;
    logic next_swPulse;
    logic [31:0] next_regRdata;

    logic [255:0] flag;
    logic [255:0] next_flag;
    logic [4:0] nmiStat;
    logic [4:0] next_nmiStat;

    logic wrMisc;
    assign wrMisc = regWr && regAddr[9:8] == `MIC_REGION_MISC;

    always_comb begin
        next_prio = prio;
        next_dtcEn = dtcEn;
        next_fastSel = fastSel;
        next_pinMode = pinMode;
        next_filtEn = filtEn;
        next_nmiEdgeRise = nmiEdgeRise;
        next_nmiEn = nmiEn;
        next_power = power;
        next_swPulse = 1'b0;
        if (regWr) begin
            case (regAddr[9:8])
                `MIC_REGION_PRIO: next_prio[regAddr[7:0]] = regWdata[PRIO_W-1:0];
                `MIC_REGION_DTCEN: next_dtcEn[regAddr[7:0]] = regWdata[0];
                `MIC_REGION_MISC: begin
                    case (regAddr[7:0])
                        `MIC_MISC_SWINT: next_swPulse = regWdata[0];
                        `MIC_MISC_FAST: next_fastSel = regWdata[8:0];
                        `MIC_MISC_PINMODE: next_pinMode = regWdata[15:0];
                        `MIC_MISC_FILTEN: next_filtEn = regWdata[8:0];
                        `MIC_MISC_NMIEDGE: next_nmiEdgeRise = regWdata[0];
                        `MIC_MISC_NMIEN: next_nmiEn = regWdata[4:0];
                        `MIC_MISC_POWER: next_power = mic_pkg::mic_power_e'(regWdata[1:0]);
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 256; i++) begin
                prio[i] <= '0;
            end
            dtcEn <= '0;
            fastSel <= '0;
            pinMode <= `MIC_PINMODE_RESET;
            filtEn <= `MIC_FILTEN_RESET;
            nmiEdgeRise <= 1'b0;
            nmiEn <= `MIC_NMIEN_RESET;
            power <= mic_pkg::MIC_PWR_RUN;
            swPulse <= 1'b0;
        end else begin
            prio <= next_prio;
            dtcEn <= next_dtcEn;
            fastSel <= next_fastSel;
            pinMode <= next_pinMode;
            filtEn <= next_filtEn;
            nmiEdgeRise <= next_nmiEdgeRise;
            nmiEn <= next_nmiEn;
            power <= next_power;
            swPulse <= next_swPulse;
        end
    end

    // ****************************************
    // source detection and request flags
    // ****************************************
    logic [255:0] src;
    logic [255:0] srcPrev;
    logic [7:0] pinPrev;
    logic [255:0] hit;
    logic [255:0] isLevel;
    logic [255:0] accepted;

    always_comb begin
        src = periphReq;
        src[EVA_VEC] = eventLinkA;
        src[EVB_VEC] = eventLinkB;
        src[RTC_ALM_VEC] = rtcAlarm;
        src[RTC_PRD_VEC] = rtcPeriod;
        isLevel = LEVEL_MASK;
        isLevel[EVA_VEC] = 1'b0;
        isLevel[EVB_VEC] = 1'b0;
        isLevel[RTC_ALM_VEC] = 1'b0;
        isLevel[RTC_PRD_VEC] = 1'b0;
        isLevel[SW_VEC] = 1'b0;
        hit = (src & isLevel) | (src & ~srcPrev & ~isLevel);
        hit[SW_VEC] = swPulse;
        for (int i = 0; i < 8; i++) begin
            case (mic_pkg::mic_pin_mode_e'(pinMode[2*i +: 2]))
                mic_pkg::MIC_PIN_LOW: hit[PIN_BASE_VEC + 8'(i)] = ~pinF[i];
                mic_pkg::MIC_PIN_FALL: hit[PIN_BASE_VEC + 8'(i)] = pinPrev[i] & ~pinF[i];
                mic_pkg::MIC_PIN_RISE: hit[PIN_BASE_VEC + 8'(i)] = ~pinPrev[i] & pinF[i];
                mic_pkg::MIC_PIN_BOTH: hit[PIN_BASE_VEC + 8'(i)] = pinPrev[i] ^ pinF[i];
                default: hit[PIN_BASE_VEC + 8'(i)] = 1'b0;
            endcase
            isLevel[PIN_BASE_VEC + 8'(i)] = pinMode[2*i +: 2] == mic_pkg::MIC_PIN_LOW;
        end
        accepted = '0;
        if (cpuAck && cpuIrq) begin
            accepted[cpuVec] = 1'b1;
        end
        if (dtcAck && dtcReq) begin
            accepted[dtcVec] = 1'b1;
        end
        for (int v = 0; v < 256; v++) begin
            if (v < `MIC_FIRST_FLAG_VEC) begin
                next_flag[v] = 1'b0;
            end else if (isLevel[v]) begin
                next_flag[v] = hit[v];
            end else begin
                next_flag[v] = (flag[v] & ~accepted[v]) | hit[v];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            srcPrev <= '0;
            pinPrev <= 8'hff;
            flag <= '0;
        end else begin
            srcPrev <= src;
            pinPrev <= pinF[7:0];
            flag <= next_flag;
        end
    end

    // ****************************************
    // non-maskable sources
    // ****************************************
    logic [4:0] nmiSrc;
    logic [4:0] nmiPrev;
    logic [4:0] nmiHit;
    logic pinNmiPrev;
    logic [4:0] nmiClr;

    always_comb begin
        nmiSrc = {voltMonTwo, voltMonOne, watchdogFault, oscStop, 1'b0};
        nmiHit = nmiSrc & ~nmiPrev;
        nmiHit[`MIC_NMI_PIN_BIT] = nmiEdgeRise ? (~pinNmiPrev & pinF[8]) : (pinNmiPrev & ~pinF[8]);
        nmiClr = wrMisc && regAddr[7:0] == `MIC_MISC_NMICLR ? regWdata[4:0] : 5'h00;
        next_nmiStat = (nmiStat & ~nmiClr) | nmiHit;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nmiPrev <= '0;
            pinNmiPrev <= 1'b1;
            nmiStat <= '0;
        end else begin
            nmiPrev <= nmiSrc;
            pinNmiPrev <= pinF[8];
            nmiStat <= next_nmiStat;
        end
    end

    // ****************************************
    // arbitration and outputs
    // ****************************************
    logic bestFound;
    logic [7:0] bestVec;
    logic [PRIO_W-1:0] bestPrio;
    logic dtcFound;
    logic [7:0] dtcSel;
    logic toDtc;
    logic pinOrRtc;
    logic next_wake;

    always_comb begin
        bestFound = 1'b0;
        bestVec = 8'h00;
        bestPrio = '0;
        dtcFound = 1'b0;
        dtcSel = 8'h00;
        toDtc = 1'b0;
        for (int v = `MIC_FIRST_FLAG_VEC; v < 256; v++) begin
            toDtc = v >= `MIC_FIRST_DTC_VEC && dtcEn[v];
            if (flag[v] && !toDtc && prio[v] > bestPrio) begin
                bestFound = 1'b1;
                bestVec = 8'(v);
                bestPrio = prio[v];
            end
        end
        for (int v = 255; v >= `MIC_FIRST_DTC_VEC; v--) begin
            if (flag[v] && dtcEn[v]) begin
                dtcFound = 1'b1;
                dtcSel = 8'(v);
            end
        end
        pinOrRtc = flag[RTC_ALM_VEC] | flag[RTC_PRD_VEC];
        for (int i = 0; i < 8; i++) begin
            pinOrRtc = pinOrRtc | flag[PIN_BASE_VEC + 8'(i)];
        end
        case (power)
            mic_pkg::MIC_PWR_SLEEP, mic_pkg::MIC_PWR_DEEP: next_wake = |nmiStat | bestFound | dtcFound;
            mic_pkg::MIC_PWR_STANDBY: next_wake = |nmiStat | pinOrRtc;
            default: next_wake = 1'b0;
        endcase
    end

    always_comb begin
        next_regRdata = 32'h0000_0000;
        if (regRd) begin
            case (regAddr[9:8])
                `MIC_REGION_FLAG: next_regRdata[0] = flag[regAddr[7:0]];
                `MIC_REGION_PRIO: next_regRdata[PRIO_W-1:0] = prio[regAddr[7:0]];
                `MIC_REGION_DTCEN: next_regRdata[0] = dtcEn[regAddr[7:0]];
                default: begin
                    case (regAddr[7:0])
                        `MIC_MISC_FAST: next_regRdata[8:0] = fastSel;
                        `MIC_MISC_PINMODE: next_regRdata[15:0] = pinMode;
                        `MIC_MISC_FILTEN: next_regRdata[8:0] = filtEn;
                        `MIC_MISC_NMIEDGE: next_regRdata[0] = nmiEdgeRise;
                        `MIC_MISC_NMISTAT: next_regRdata[4:0] = nmiStat;
                        `MIC_MISC_NMIEN: next_regRdata[4:0] = nmiEn;
                        `MIC_MISC_POWER: next_regRdata[1:0] = power;
                        `MIC_MISC_PEND: next_regRdata = {cpuIrq, dtcReq, cpuFast, 5'h00, dtcVec, 8'h00, cpuVec};
                        default: ;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpuIrq <= 1'b0;
            cpuVec <= 8'h00;
            cpuLevel <= '0;
            cpuFast <= 1'b0;
            dtcReq <= 1'b0;
            dtcVec <= 8'h00;
            nmiIrq <= 1'b0;
            wakeReq <= 1'b0;
            regRdata <= 32'h0000_0000;
        end else begin
            // an accepted request drops for one cycle; the next candidate shows on the following edge
            cpuIrq <= bestFound & ~(cpuAck & cpuIrq);
            cpuVec <= bestVec;
            cpuLevel <= bestPrio;
            cpuFast <= bestFound & ~(cpuAck & cpuIrq) & fastSel[`MIC_FAST_EN_BIT] & (fastSel[7:0] == bestVec);
            dtcReq <= dtcFound & ~(dtcAck & dtcReq);
            dtcVec <= dtcSel;
            nmiIrq <= |(next_nmiStat & nmiEn);
            wakeReq <= next_wake;
            regRdata <= next_regRdata;
        end
    end

endmodule

// *** mic_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the interrupt unit.
 * Assumes word addressing on the plain register port: one index per 32-bit register.
 */
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// ****************************************
// address regions, index bits [9:8]
// ****************************************
`define MIC_REGION_FLAG 2'h0
`define MIC_REGION_PRIO 2'h1
`define MIC_REGION_DTCEN 2'h2
`define MIC_REGION_MISC 2'h3

// ****************************************
// misc registers, index bits [7:0]
// ****************************************
`define MIC_MISC_SWINT 8'h00
`define MIC_MISC_FAST 8'h01
`define MIC_MISC_PINMODE 8'h02
`define MIC_MISC_FILTEN 8'h03
`define MIC_MISC_NMIEDGE 8'h04
`define MIC_MISC_NMISTAT 8'h05
`define MIC_MISC_NMICLR 8'h06
`define MIC_MISC_NMIEN 8'h07
`define MIC_MISC_POWER 8'h08
`define MIC_MISC_PEND 8'h09

// ****************************************
// fields
// ****************************************
`define MIC_FAST_EN_BIT 8
`define MIC_FILT_NMI_BIT 8
`define MIC_NMI_PIN_BIT 0
`define MIC_NMI_OSC_BIT 1
`define MIC_NMI_WDT_BIT 2
`define MIC_NMI_VM1_BIT 3
`define MIC_NMI_VM2_BIT 4
`define MIC_PEND_IRQ_BIT 31
`define MIC_PEND_DTC_BIT 30
`define MIC_PEND_FAST_BIT 29

// ****************************************
// vector limits, reset values and filter length
// ****************************************
`define MIC_FIRST_FLAG_VEC 16
`define MIC_FIRST_DTC_VEC 27
`define MIC_NMIEN_RESET 5'h1f
`define MIC_PINMODE_RESET 16'h0000
`define MIC_FILTEN_RESET 9'h000
`define MIC_FILT_LEN 3

`endif

// *** mic_pkg.sv ***
/*
 * Types shared by the interrupt unit files.
 * Assumes mic_regs.svh supplies all numeric constants.
 */
package mic_pkg;

    typedef enum logic [1:0] {
        MIC_PIN_LOW = 2'b00,
        MIC_PIN_FALL = 2'b01,
        MIC_PIN_RISE = 2'b10,
        MIC_PIN_BOTH = 2'b11
    } mic_pin_mode_e;

    typedef enum logic [1:0] {
        MIC_PWR_RUN = 2'b00,
        MIC_PWR_SLEEP = 2'b01,
        MIC_PWR_DEEP = 2'b10,
        MIC_PWR_STANDBY = 2'b11
    } mic_power_e;

endpackage

// *** mic_pin_filter.sv ***
/*
 * Digital noise filter for one interrupt pin.
 * Assumes the pin is already synchronous to sys_clk.
 */
`timescale 1ns/1ps

module mic_pin_filter #(
    parameter int LEN = 3,
    parameter logic IDLE = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic pin,
    output logic filtered
);

    logic [$clog2(LEN+1)-1:0] count;
    logic [$clog2(LEN+1)-1:0] next_count;
    logic next_filtered;

    // with enable set, a level passes only after LEN equal samples; with enable clear, the pin passes through directly
    always_comb begin
        next_count = '0;
        next_filtered = filtered;
        if (!enable) begin
            next_filtered = pin;
        end else if (pin != filtered) begin
            next_count = count + 1'b1;
            if (next_count == ($clog2(LEN+1))'(LEN)) begin
                next_filtered = pin;
                next_count = '0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= '0;
            filtered <= IDLE;
        end else begin
            count <= next_count;
            filtered <= next_filtered;
        end
    end

endmodule

// *** mic_checker_sva.sv ***
/* checker for the interrupt unit ports.
   assumes the non-maskable enables keep their reset value */
`timescale 1ns/1ps
module mic_checker #(
    parameter int PRIO_W = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [9:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic oscStop,
    input wire logic watchdogFault,
    input wire logic voltMonOne,
    input wire logic voltMonTwo,
    input wire logic cpuAck,
    input wire logic dtcAck,
    input wire logic cpuIrq,
    input wire logic [7:0] cpuVec,
    input wire logic [PRIO_W-1:0] cpuLevel,
    input wire logic cpuFast,
    input wire logic dtcReq,
    input wire logic [7:0] dtcVec,
    input wire logic nmiIrq,
    input wire logic wakeReq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****************
    // assertions
    // ****************
    a_read_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside its slot");
    a_pend_read: assert property (regRd && regAddr == 10'h309 |=>
        regRdata[31] == $past(cpuIrq) && regRdata[7:0] == $past(cpuVec)) else $error("pending word wrong");
    a_irq_level: assert property (cpuIrq |-> cpuLevel != '0)
        else $error("zero level presented");
    a_cpu_ack: assert property (cpuIrq && cpuAck |=> !cpuIrq)
        else $error("request kept after accept");
    a_dtc_ack: assert property (dtcReq && dtcAck |=> !dtcReq)
        else $error("activation kept after accept");
    a_dtc_range: assert property (dtcReq |-> dtcVec >= 8'h1b)
        else $error("activation below first transfer vector");
    a_cpu_range: assert property (cpuIrq |-> cpuVec >= 8'h10)
        else $error("vector without flag presented");
    a_fast_only: assert property (cpuFast |-> cpuIrq)
        else $error("fast mark without request");
    a_nmi_event: assert property ($rose(oscStop) || $rose(watchdogFault) || $rose(voltMonOne) ||
        $rose(voltMonTwo) |=> nmiIrq) else $error("nmi source missed");
    a_nmi_hold: assert property (nmiIrq && !(regWr && regAddr inside {10'h306, 10'h307}) |=> nmiIrq)
        else $error("nmi dropped without clear");
    cover property (cpuIrq && cpuAck && cpuFast);
    cover property (dtcReq && dtcAck);
    cover property (nmiIrq);
    cover property (wakeReq);
endmodule

bind mic_interrupt_unit mic_checker #(.PRIO_W(PRIO_W)) chk_i (.sys_clk, .rst, .regAddr, .regWr, .regRd,
    .regRdata, .oscStop, .watchdogFault, .voltMonOne, .voltMonTwo, .cpuAck, .dtcAck, .cpuIrq, .cpuVec,
    .cpuLevel, .cpuFast, .dtcReq, .dtcVec, .nmiIrq, .wakeReq);

// *** mic_host_model.sv ***
/* cpu and transfer controller accept model.
   assumes level requests; accepts WAIT+1 cycles after a request shows */
`timescale 1ns/1ps
module mic_host_model #(
    parameter int WAIT = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ackEn,
    input wire logic cpuIrq,
    input wire logic dtcReq,
    output logic cpuAck,
    output logic dtcAck
);
    logic [1:0] req;
    logic [1:0] ack;
    logic [1:0] next_ack;
    int cnt [2];
    int next_cnt [2];
    assign req = {dtcReq, cpuIrq};
    assign cpuAck = ack[0];
    assign dtcAck = ack[1];
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_ack[i] = 1'b0;
            next_cnt[i] = 0;
            if (req[i] && ackEn && !ack[i]) begin
                next_cnt[i] = cnt[i] + 1;
                next_ack[i] = (cnt[i] >= WAIT);
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack <= '0;
            cnt <= '{0, 0};
        end else begin
            ack <= next_ack;
            cnt <= next_cnt;
        end
    end
endmodule

// *** testbench.sv ***
/* testbench: register tasks, source stimulus, accept order checks.
   assumes mic_host_model accepts three cycles after a request */
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] regAddr = 10'h000;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [255:0] periphReq = '0;
    logic [7:0] extPin = 8'hff;
    logic nmiPin = 1'b1;
    logic [6:0] src = 7'h00;
    logic ackEn = 1'b0;
    logic rtcPeriod = 1'b0;
    logic [31:0] regRdata;
    logic cpuAck, dtcAck, cpuIrq, cpuFast, dtcReq, nmiIrq, wakeReq;
    logic [7:0] cpuVec, dtcVec;
    logic [3:0] cpuLevel;
    logic [8:0] cpuSeen [$];
    logic [7:0] dtcSeen [$];
    int num_errors = 0;
    int compares = 0;

    always #50 sys_clk = ~sys_clk;

    mic_interrupt_unit #(.LEVEL_MASK(256'h1 << 40)) dut (.sys_clk, .rst, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .periphReq, .extPin, .nmiPin, .eventLinkA(src[0]), .eventLinkB(src[1]), .rtcAlarm(src[2]),
        .rtcPeriod, .oscStop(src[3]), .watchdogFault(src[4]), .voltMonOne(src[5]), .voltMonTwo(src[6]),
        .cpuAck, .dtcAck, .cpuIrq, .cpuVec, .cpuLevel, .cpuFast, .dtcReq, .dtcVec, .nmiIrq, .wakeReq);
    mic_host_model #(.WAIT(2)) partner (.sys_clk, .rst, .ackEn, .cpuIrq, .dtcReq, .cpuAck, .dtcAck);

    always @(posedge sys_clk) begin
        if (cpuAck === 1'b1 && cpuIrq === 1'b1) cpuSeen.push_back({cpuFast, cpuVec});
        if (dtcAck === 1'b1 && dtcReq === 1'b1) dtcSeen.push_back(dtcVec);
    end
    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 chk(regRdata, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic complete_run;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        #400000;
        num_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        complete_run;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(10'h307, 32'h1f);
        wr(10'h140, 32'h3);
        rd(10'h140, 32'h3);
        wr(10'h320, 32'hff);
        rd(10'h320, 32'h0);
        done("registers");
        wr(10'h128, 32'h4);
        wr(10'h132, 32'h2);
        wr(10'h13c, 32'h5);
        wr(10'h13d, 32'h5);
        @(posedge sys_clk) periphReq <= (256'h1 << 40) | (256'h1 << 50) | (256'h3 << 60);
        @(posedge sys_clk) periphReq <= 256'h1 << 40;
        cyc(3);
        rd(10'h032, 32'h1);
        rd(10'h028, 32'h1);
        rd(10'h309, 32'h8000003c);
        chk(cpuLevel, 32'h5);
        @(posedge sys_clk) periphReq <= '0;
        cyc(3);
        rd(10'h028, 32'h0);
        @(posedge sys_clk) ackEn <= 1'b1;
        cyc(30);
        chk(cpuSeen.pop_front(), 9'h03c);
        chk(cpuSeen.pop_front(), 9'h03d);
        chk(cpuSeen.pop_front(), 9'h032);
        done("priority");
        wr(10'h140, 32'h1);
        wr(10'h141, 32'h1);
        wr(10'h142, 32'h1);
        wr(10'h302, 32'h39);
        wr(10'h303, 32'h1ff);
        @(posedge sys_clk) extPin <= 8'hf0;
        cyc(10);
        @(posedge sys_clk) extPin <= 8'hf2;
        @(posedge sys_clk) extPin <= 8'hf0;
        cyc(10);
        rd(10'h043, 32'h1);
        @(posedge sys_clk) extPin <= 8'hff;
        cyc(30);
        rd(10'h043, 32'h0);
        chk(cpuSeen.pop_front(), 9'h040);
        chk(cpuSeen.pop_front(), 9'h042);
        chk(cpuSeen.pop_front(), 9'h041);
        chk(cpuSeen.pop_front(), 9'h042);
        chk(cpuSeen.size(), 0);
        done("pins");
        wr(10'h21b, 32'h1);
        wr(10'h11b, 32'h1);
        wr(10'h16a, 32'h3);
        wr(10'h16b, 32'h3);
        wr(10'h301, 32'h16b);
        wr(10'h300, 32'h1);
        @(posedge sys_clk) src <= 7'h03;
        @(posedge sys_clk) src <= 7'h00;
        cyc(20);
        chk(dtcSeen.pop_front(), 8'h1b);
        chk(cpuSeen.pop_front(), 9'h06a);
        chk(cpuSeen.pop_front(), 9'h16b);
        chk(cpuSeen.size(), 0);
        done("software and link");
        @(posedge sys_clk) nmiPin <= 1'b0;
        @(posedge sys_clk) src <= 7'h78;
        @(posedge sys_clk) src <= 7'h00;
        cyc(8);
        rd(10'h305, 32'h1f);
        chk(nmiIrq, 1'b1);
        wr(10'h306, 32'h1f);
        rd(10'h305, 32'h0);
        chk(nmiIrq, 1'b0);
        wr(10'h304, 32'h1);
        @(posedge sys_clk) nmiPin <= 1'b1;
        cyc(8);
        rd(10'h305, 32'h1);
        wr(10'h306, 32'h1);
        done("nmi");
        @(posedge sys_clk) ackEn <= 1'b0;
        wr(10'h15c, 32'h1);
        wr(10'h308, 32'h3);
        @(posedge sys_clk) periphReq <= 256'h1 << 50;
        @(posedge sys_clk) periphReq <= '0;
        cyc(4);
        chk(wakeReq, 1'b0);
        @(posedge sys_clk) src <= 7'h04;
        @(posedge sys_clk) src <= 7'h00;
        cyc(4);
        chk(wakeReq, 1'b1);
        wr(10'h308, 32'h1);
        @(posedge sys_clk) ackEn <= 1'b1;
        cyc(20);
        chk(wakeReq, 1'b0);
        @(posedge sys_clk) ackEn <= 1'b0;
        @(posedge sys_clk) periphReq <= 256'h1 << 61;
        @(posedge sys_clk) periphReq <= '0;
        cyc(4);
        chk(wakeReq, 1'b1);
        @(posedge sys_clk) ackEn <= 1'b1;
        cyc(10);
        chk(cpuSeen.pop_front(), 9'h032);
        chk(cpuSeen.pop_front(), 9'h05c);
        chk(cpuSeen.pop_front(), 9'h03d);
        wr(10'h308, 32'h3);
        cyc(2);
        chk(wakeReq, 1'b0);
        @(posedge sys_clk) rtcPeriod <= 1'b1;
        @(posedge sys_clk) rtcPeriod <= 1'b0;
        cyc(4);
        chk(wakeReq, 1'b1);
        wr(10'h308, 32'h0);
        done("wake");
        complete_run;
    end
endmodule
